// [core/scdir_regs.svh]
// Register offsets, field positions and reset values for the serial card glue
`ifndef SCDIR_REGS_SVH
`define SCDIR_REGS_SVH
// Word addresses on the Avalon side (byte address / 4)
`define SCDIR_ADDR_W        3
`define SCDIR_REG_CFG       3'h0
`define SCDIR_REG_IRQSEL    3'h1
`define SCDIR_REG_STATUS    3'h2
`define SCDIR_REG_MASK      3'h3
`define SCDIR_REG_LIVE      3'h4
// Config register fields
`define SCDIR_CFG_SW_LSB    0
`define SCDIR_CFG_SW_MSB    6
`define SCDIR_CFG_EN_BIT    7                    // Set = switch open = port off
`define SCDIR_CFG_PD_BIT    8
`define SCDIR_CFG_RTS_BIT   9
// Reset values: base 0x280 -> switches A9..A3 = 1010000, port on, pull-down on, RTS mode
`define SCDIR_CFG_RESET     10'h350
`define SCDIR_IRQSEL_RESET  4'h3
// Status bits
`define SCDIR_ST_HIT        0
`define SCDIR_ST_IRQ        1
`define SCDIR_ST_W          2
// Host bus fields
`define SCDIR_HA_MSB        9
`define SCDIR_HA_LSB        3
`define SCDIR_OFS_W         3
`define SCDIR_NLINES        10
`endif

// [core/scdir_pkg.sv]
// Types shared by the serial card glue
package scdir_pkg;
  // Request line choices, in selector order
  typedef enum logic [3:0] {
    SCDIR_IRQ2_9 = 4'h0,
    SCDIR_IRQ3   = 4'h1,
    SCDIR_IRQ4   = 4'h2,
    SCDIR_IRQ5   = 4'h3,
    SCDIR_IRQ7   = 4'h4,
    SCDIR_IRQ10  = 4'h5,
    SCDIR_IRQ11  = 4'h6,
    SCDIR_IRQ12  = 4'h7,
    SCDIR_IRQ15  = 4'h8
  } scdir_irq_t;
  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    SCDIR_IDLE = 2'b01,
    SCDIR_DONE = 2'b10
  } scdir_bus_t;
endpackage : scdir_pkg

// [core/scdir_top.sv]
// Serial card glue: I/O window decode, port gate, IRQ routing, RS-485 driver enable
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`include "scdir_regs.svh"
module scdir_top #(
  parameter int NIRQ = 9                          // Number of selectable request lines
) (
  input  wire logic        mclk_i,                // 50 MHz system clock
  input  wire logic        rst_i,                 // Async reset, active high
  // Avalon-MM slave
  input  wire logic [`SCDIR_ADDR_W-1:0] avs_address_i,     // Word address
  input  wire logic        avs_read_i,            // Read strobe
  input  wire logic        avs_write_i,           // Write strobe
  input  wire logic [31:0] avs_writedata_i,       // Write data
  input  wire logic [3:0]  avs_byteenable_i,      // Byte enables
  output logic      [31:0] avs_readdata_o,        // Read data
  output logic             avs_waitrequest_o,     // Stall
  output logic             irq_o,                 // Level interrupt to software
  // Host expansion bus (pins)
  input  wire logic [`SCDIR_NLINES-1:0] host_addr_i, // SA9..SA0
  input  wire logic        host_aen_i,            // Address enable, high = DMA cycle
  // UART side
  input  wire logic        uart_irq_i,            // UART interrupt, active high
  input  wire logic        uart_rts_n_i,          // UART RTS, active low
  output logic             uart_cs_o,             // UART chip select
  output logic [`SCDIR_OFS_W-1:0] uart_ofs_o,     // UART register offset
  // Request lines: tri-state drivers and pull-down
  output logic [NIRQ-1:0]  irq_line_o,            // Drive value per line
  output logic [NIRQ-1:0]  irq_line_oe_o,         // Driver enable per line
  output logic             irq_pulldown_o,        // Pull-down jumper connected
  // RS-485 transmitter
  output logic             tx_drv_en_o            // Transmit driver enable
);

  // Pin synchronisers, two stages each
  logic [`SCDIR_NLINES-1:0] addr_s1, addr_s2;     // Address pins
  logic [2:0]               misc_s1, misc_s2;     // aen, irq, rts_n

  // Software visible state
  logic [9:0]  cfg;                               // Switch bank, enable, pull-down, rts mode
  logic [3:0]  irq_line_selector;                 // Request line choice
  logic [`SCDIR_ST_W-1:0] status;                 // Sticky events
  logic [`SCDIR_ST_W-1:0] mask;                   // Event mask
  scdir_pkg::scdir_bus_t  bus_st;                 // Slave state
  logic        hit_q;                             // Previous decode, for edge event
  logic        uirq_q;                            // Previous UART irq

  // Decoded configuration
  logic [6:0]  base_select_switch_bank;           // 1 = open switch
  logic        port_en;                           // Position eight closed
  logic        driver_enable_selector;            // 1 = RTS mode
  logic        next_cs;                           // Decode result
  logic        next_drv;                          // Driver enable result
  logic        rd_acc, wr_acc;                    // Accepted access

  assign base_select_switch_bank = cfg[`SCDIR_CFG_SW_MSB:`SCDIR_CFG_SW_LSB];
  assign port_en                 = !cfg[`SCDIR_CFG_EN_BIT]; // Open switch disables
  assign driver_enable_selector  = cfg[`SCDIR_CFG_RTS_BIT];
  assign rd_acc = avs_read_i && bus_st == scdir_pkg::SCDIR_IDLE;
  assign wr_acc = avs_write_i && bus_st == scdir_pkg::SCDIR_IDLE;

  // Base match over A9..A3 only; upper lines are not even present
  function automatic logic base_match(input logic [`SCDIR_NLINES-1:0] a,
                                      input logic [6:0] sw);
    base_match = (a[`SCDIR_HA_MSB:`SCDIR_HA_LSB] == sw);
  endfunction : base_match

  // Synchronise pins before any logic looks at them
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      misc_s1 <= 3'h5;                            // AEN high, RTS idle
      misc_s2 <= 3'h5;
    end
    else
    begin
      addr_s1 <= host_addr_i;
      addr_s2 <= addr_s1;
      misc_s1 <= {uart_rts_n_i, uart_irq_i, host_aen_i};
      misc_s2 <= misc_s1;
    end
  end

  // Decode: AEN low, port enabled, A9..A3 match
  assign next_cs = !misc_s2[0] && port_en
                   && base_match(addr_s2, base_select_switch_bank);

  // Driver enable: RTS mode follows RTS, else always on
  assign next_drv = driver_enable_selector ? !misc_s2[2] : 1'b1;

  // Chip select and window offset to the UART
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      uart_cs_o  <= 1'b0;
      uart_ofs_o <= '0;
    end
    else
    begin
      uart_cs_o  <= next_cs;
      uart_ofs_o <= addr_s2[`SCDIR_OFS_W-1:0];    // Low three bits pick location
    end
  end

  // Interrupt routing: drive high on one line only; released when disabled
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_line_o    <= '0;
      irq_line_oe_o <= '0;
    end
    else
    begin
      irq_line_o    <= '0;
      irq_line_oe_o <= '0;
      // Never drive low: the pull-down alone returns the line, so cards can share it
      if (port_en && misc_s2[1] && irq_line_selector < NIRQ)
      begin
        irq_line_o[irq_line_selector]    <= 1'b1;
        irq_line_oe_o[irq_line_selector] <= 1'b1;
      end
    end
  end

  // Pull-down jumper and transmit enable
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_pulldown_o <= 1'b1;
      tx_drv_en_o    <= 1'b0;
    end
    else
    begin
      irq_pulldown_o <= cfg[`SCDIR_CFG_PD_BIT];
      tx_drv_en_o    <= next_drv;
    end
  end

  // Configuration writes, byte-lane aware; defaults give 280h, line 5
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg               <= `SCDIR_CFG_RESET;
      irq_line_selector <= `SCDIR_IRQSEL_RESET;
      mask              <= '0;
    end
    else if (wr_acc)
    begin
      case (avs_address_i)
        `SCDIR_REG_CFG:
        begin
          if (avs_byteenable_i[0])
            cfg[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1])
            cfg[9:8] <= avs_writedata_i[9:8];
        end
        `SCDIR_REG_IRQSEL:
        begin
          // Out-of-range codes ignored so exactly one line stays chosen
          if (avs_byteenable_i[0] && avs_writedata_i[3:0] < NIRQ)
            irq_line_selector <= avs_writedata_i[3:0];
        end
        `SCDIR_REG_MASK:
        begin
          if (avs_byteenable_i[0])
            mask <= avs_writedata_i[`SCDIR_ST_W-1:0];
        end
        default:
        begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // Sticky events: window hit and UART irq rise; set wins over read-clear
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status <= '0;
      hit_q  <= 1'b0;
      uirq_q <= 1'b0;
    end
    else
    begin
      hit_q  <= next_cs;
      uirq_q <= misc_s2[1];
      status <= ((rd_acc && avs_address_i == `SCDIR_REG_STATUS) ? '0 : status)
                | {misc_s2[1] && !uirq_q, next_cs && !hit_q};
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status & mask);
  end

  // Bus slave: one wait cycle, answer on the second edge
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_st            <= scdir_pkg::SCDIR_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end
    else
    begin
      case (bus_st)
        scdir_pkg::SCDIR_IDLE:
        begin
          avs_waitrequest_o <= 1'b1;
          if (avs_read_i || avs_write_i)
          begin
            bus_st            <= scdir_pkg::SCDIR_DONE;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= '0;          // Unmapped reads give zero
            if (avs_read_i)
            begin
              case (avs_address_i)
                `SCDIR_REG_CFG:    avs_readdata_o <= {22'h0, cfg};
                `SCDIR_REG_IRQSEL: avs_readdata_o <= {28'h0, irq_line_selector};
                `SCDIR_REG_STATUS: avs_readdata_o <= {30'h0, status};
                `SCDIR_REG_MASK:   avs_readdata_o <= {30'h0, mask};
                `SCDIR_REG_LIVE:   avs_readdata_o <= {29'h0, tx_drv_en_o, uart_cs_o, irq_o};
                default:           avs_readdata_o <= '0;
              endcase
            end
          end
        end
        scdir_pkg::SCDIR_DONE:
        begin
          bus_st            <= scdir_pkg::SCDIR_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default:
        begin
          bus_st            <= scdir_pkg::SCDIR_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Checks
  a_cs_needs_match: assert property (@(posedge mclk_i) disable iff (rst_i)
    uart_cs_o |-> $past(port_en) && !$past(misc_s2[0])
      && $past(addr_s2[`SCDIR_HA_MSB:`SCDIR_HA_LSB]) == $past(base_select_switch_bank))
    else $error("chip select without a decoded match");
  a_cs_on_match: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!misc_s2[0] && port_en && addr_s2[`SCDIR_HA_MSB:`SCDIR_HA_LSB] == base_select_switch_bank)
      |=> uart_cs_o)
    else $error("matching access not selected");
  a_disabled_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!port_en ##1 !port_en) |-> !uart_cs_o)
    else $error("disabled port responded");
  a_no_drive_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!port_en ##1 !port_en) |-> irq_line_oe_o == '0)
    else $error("disabled port drives request line");
  a_one_line: assert property (@(posedge mclk_i) disable iff (rst_i)
    $onehot0(irq_line_oe_o))
    else $error("more than one request line driven");
  a_irq_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
    (port_en && misc_s2[1])
      |=> irq_line_oe_o[$past(irq_line_selector)] && irq_line_o[$past(irq_line_selector)])
    else $error("uart interrupt not driven on chosen line");
  a_rts_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
    (driver_enable_selector && misc_s2[2]) |=> !tx_drv_en_o)
    else $error("driver enabled without rts");
  a_fixed_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
    !driver_enable_selector |=> tx_drv_en_o)
    else $error("driver not enabled in fixed mode");
  a_offset_pass: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 uart_ofs_o == $past(addr_s2[`SCDIR_OFS_W-1:0]))
    else $error("window offset mismatch");

endmodule : scdir_top

// [test/scdir_line_model.sv]
// Request line wires: tri-state drivers resolved against the optional pull-down
module scdir_line_model (
  input  wire logic       mclk_i, // System clock
  input  wire logic [8:0] drv_i,  // Drive value per line
  input  wire logic [8:0] oe_i,   // Driver enable per line
  input  wire logic       pd_i,   // Pull-down fitted
  output logic      [8:0] lvl_o   // Resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] last = '0;          // Previous wire level
  // Remember the level so a floating line can wander away from it
  always_ff @(posedge mclk_i)
  begin
    last <= lvl_o;
  end
  // A released line without pull-down never keeps its old value
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      lvl_o[i] = oe_i[i] ? drv_i[i] : (pd_i ? 1'b0 : ~last[i]);
    end
  end
endmodule : scdir_line_model

// [test/test_serial_card_io_decode_irq_route.sv]
// Self-checking bench for the serial card glue
`include "scdir_regs.svh"
module test_serial_card_io_decode_irq_route;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rst_i, avs_read_i, avs_write_i, host_aen_i; // Bench drives
  logic        uart_irq_i, uart_rts_n_i, avs_waitrequest_o, irq_o; // Single bits
  logic        uart_cs_o, irq_pulldown_o, tx_drv_en_o;             // Outputs
  logic [2:0]  avs_address_i, uart_ofs_o;                          // Addresses
  logic [31:0] avs_writedata_i, avs_readdata_o;                    // Bus data
  logic [9:0]  host_addr_i;                                        // Host pins
  logic [8:0]  irq_line_o, irq_line_oe_o, lvl;                     // Request lines
  int          bad_count, checked;                                 // Tallies
  scdir_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .host_addr_i(host_addr_i),
    .host_aen_i(host_aen_i), .uart_irq_i(uart_irq_i), .uart_rts_n_i(uart_rts_n_i),
    .uart_cs_o(uart_cs_o), .uart_ofs_o(uart_ofs_o), .irq_line_o(irq_line_o),
    .irq_line_oe_o(irq_line_oe_o), .irq_pulldown_o(irq_pulldown_o), .tx_drv_en_o(tx_drv_en_o));
  scdir_line_model line_u (.mclk_i(mclk_i), .drv_i(irq_line_o), .oe_i(irq_line_oe_o),
    .pd_i(irq_pulldown_o), .lvl_o(lvl));
  // 50 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus
  task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    // No cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge mclk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus_xfer
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus_xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus_xfer(1'b0, a, 32'h0, x);
    chk_bus(x, exp);
  endtask : rd_chk
  // Pins pass two sync stages and an output register
  task automatic settle;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle
  task automatic host_chk(input logic [9:0] a, input logic aen, input logic cs);
    @(posedge mclk_i);
    host_addr_i <= a;
    host_aen_i <= aen;
    settle();
    chk_pin({uart_cs_o, uart_ofs_o}, {cs, a[2:0]});
  endtask : host_chk
  task automatic tally_and_finish;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin : main_seq
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {rst_i, host_aen_i, uart_rts_n_i, uart_irq_i, host_addr_i} = {4'b1110, 10'h0};
    bad_count = 0;
    checked = 0;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_chk(`SCDIR_REG_CFG, 32'h350);
    rd_chk(`SCDIR_REG_IRQSEL, 32'h3);
    rd_chk(`SCDIR_REG_MASK, 32'h0);
    rd_chk(3'h7, 32'h0);
    chk_pin(10'(irq_pulldown_o), 10'h1);
    // Edges of the default window, one below and one above
    for (int i = 0; i < 10; i++)
      host_chk(10'h27f + 10'(i), 1'b0, i > 0 && i < 9);
    host_chk(10'h283, 1'b1, 1'b0);
    // Hit status is masked until enabled, cleared by reading
    chk_pin(10'(irq_o), 10'h0);
    wr(`SCDIR_REG_MASK, 32'h1);
    settle();
    chk_pin(10'(irq_o), 10'h1);
    rd_chk(`SCDIR_REG_STATUS, 32'h1);
    settle();
    chk_pin(10'(irq_o), 10'h0);
    // Switch pattern 1011111 moves the window to 2f8h
    wr(`SCDIR_REG_CFG, 32'h35f);
    host_chk(10'h2fb, 1'b0, 1'b1);
    host_chk(10'h283, 1'b0, 1'b0);
    // Open enable switch: no select, no request line
    wr(`SCDIR_REG_CFG, 32'h3d0);
    uart_irq_i <= 1'b1;
    host_chk(10'h280, 1'b0, 1'b0);
    chk_pin(10'(irq_line_oe_o), 10'h0);
    wr(`SCDIR_REG_CFG, 32'h350);
    for (int k = 0; k < 9; k++)
    begin
      wr(`SCDIR_REG_IRQSEL, 32'(k));
      settle();
      chk_pin(10'(irq_line_oe_o), 10'h1 << k);
      chk_pin(10'(irq_line_o), 10'h1 << k);
      chk_pin(10'(lvl), 10'h1 << k);
    end
    @(posedge mclk_i);
    uart_irq_i <= 1'b0;
    settle();
    chk_pin(10'(lvl), 10'h0);
    // Window hit and interrupt rise both latched since the last read
    chk_pin(10'(irq_o), 10'h1);
    rd_chk(`SCDIR_REG_STATUS, 32'h3);
    rd_chk(`SCDIR_REG_STATUS, 32'h0);
    // Live view: driver off with RTS idle, select on, interrupt gone
    rd_chk(`SCDIR_REG_LIVE, 32'h2);
    wr(`SCDIR_REG_IRQSEL, 32'h9);
    rd_chk(`SCDIR_REG_IRQSEL, 32'h8);
    // Driver enable follows RTS only in RTS mode; RTS held only while sending
    uart_rts_n_i <= 1'b0;
    settle();
    chk_pin(10'(tx_drv_en_o), 10'h1);
    @(posedge mclk_i);
    uart_rts_n_i <= 1'b1;
    settle();
    chk_pin(10'(tx_drv_en_o), 10'h0);
    wr(`SCDIR_REG_CFG, 32'h050);
    settle();
    chk_pin(10'({tx_drv_en_o, irq_pulldown_o}), 10'h2);
    tally_and_finish();
  end
endmodule : test_serial_card_io_decode_irq_route
